// ### voter_cfg.svh
// Register offsets, field positions, reset values and indices of the voter
`ifndef VOTER_CFG_SVH
`define VOTER_CFG_SVH

// APB byte offsets
`define OFS_CTRL 8'h00
`define OFS_SP_BASE 8'h04
`define OFS_STATUS 8'h24

// Register indices (byte offset / 4)
`define IDX_CTRL 4'h0
`define IDX_SP_LAST 4'h8
`define IDX_STATUS 4'h9
`define IDX_NONE 4'hF

// Setpoint slots, one word each from OFS_SP_BASE upward
`define SP_FLUX_HI 3'h0
`define SP_TEMP_HI 3'h1
`define SP_PRESS_HI 3'h2
`define SP_PRESS_LO 3'h3
`define SP_PT_BIAS 3'h4
`define SP_FLOW_MGN 3'h5
`define SP_PUMP_LIM 3'h6
`define SP_BYP_FLUX 3'h7

// Reset values: high limits open, low limits closed, turbine and feedwater trips enabled
`define CTRL_RESET 1'h1
`define SP_RESET {16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, \
	16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF}

// CTRL field
`define CTRL_EN 0

// Analog parameter slots
`define P_FLUX 0
`define P_TEMP 1
`define P_PRESS 2
`define P_FLOW 3

// Pump count below which the pump limit applies
`define PUMPS_FULL 3'h4

// STATUS fields
`define ST_TRIP 0
`define ST_COINC 1
`define ST_RELAY 2
`define ST_LINKF 6
`define ST_INF 10
`define ST_OUTF 11
`define ST_BLDG1 12
`define ST_SHUNT 13
`define ST_SG 14
`define ST_SELF 15

`endif

// ### voter_pkg.sv
// Types shared by the protective channel voter
package voter_pkg;
	typedef logic [15:0] sample_t;

	// Every non-APB input pin of the channel, kept together for synchronising
	typedef struct packed {
		logic power_ok;
		logic cpu_ok;
		logic in_card_ok;
		logic out_card_ok;
		logic shunt_pwr_ok;
		logic [3:0] link_ok;
		logic [3:0] trip_in_n;
		logic [3:0] turb_open;
		logic [3:0] bldg_open;
		logic [3:0] fwa_open;
		logic [3:0] fwb_open;
		logic [2:0] pumps;
		logic [3:0][3:0][15:0] ana;
	} pins_s;

	typedef struct packed {
		pins_s sync1;
		pins_s sync2;
		logic ctrl_en;
		logic [7:0][15:0] sp;
		logic chan_trip_n;
		logic [1:0] brk_hold;
		logic input_fault_alarm;
		logic trouble_alarm;
		logic shunt_inop_alarm;
		logic safeguards_act;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_s;
endpackage : voter_pkg

// ### sel_if.sv
// Carrier between the voter and its analog selectors
`timescale 1ns/1ns
`default_nettype none
interface sel_if;
	logic [3:0][15:0] vals;
	logic [3:0] valid;
	logic [1:0] own;
	voter_pkg::sample_t hi2;
	voter_pkg::sample_t lo2;
	logic ok;
	modport src(output vals, output valid, output own,
		input hi2, input lo2, input ok);
	modport sel(input vals, input valid, input own,
		output hi2, output lo2, output ok);
endinterface : sel_if
`default_nettype wire

// ### analog_selector.sv
// Second-highest and second-lowest selection over four channel samples
`timescale 1ns/1ns
`default_nettype none
module analog_selector (
	sel_if.sel bus
);
	// Ties broken by channel index so each rank is held by one sample only
	always_comb begin
		logic [2:0] nv;
		logic [2:0] above;
		logic [2:0] below;
		nv = 3'h0;
		above = 3'h0;
		below = 3'h0;
		bus.hi2 = 16'h0000;
		bus.lo2 = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			nv = nv + {2'h0, bus.valid[i]};
		end
		// Faulted samples take no part in the ranking
		for (int i = 0; i < 4; i++) begin
			above = 3'h0;
			below = 3'h0;
			for (int j = 0; j < 4; j++) begin
				if (j != i && bus.valid[j]) begin
					if (bus.vals[j] > bus.vals[i] ||
						(bus.vals[j] == bus.vals[i] && j < i)) begin
						above = above + 3'h1;
					end
					if (bus.vals[j] < bus.vals[i] ||
						(bus.vals[j] == bus.vals[i] && j < i)) begin
						below = below + 3'h1;
					end
				end
			end
			if (bus.valid[i] && above == 3'h1) begin
				bus.hi2 = bus.vals[i]; // R12
			end
			if (bus.valid[i] && below == 3'h1) begin
				bus.lo2 = bus.vals[i]; // R12
			end
		end
		bus.ok = (nv >= 3'h2); // R13
		// A lone own hardwired sample passes straight through
		if (nv == 3'h1 && bus.valid[bus.own]) begin
			bus.hi2 = bus.vals[bus.own]; // R11
			bus.lo2 = bus.vals[bus.own]; // R11
			bus.ok = 1'b1; // R11
		end
	end
endmodule : analog_selector
`default_nettype wire

// ### protective_channel_voter.sv
// One protective channel: selection, voting, trip relays and APB registers
`timescale 1ns/1ns
`default_nettype none
`include "voter_cfg.svh"

// Behaviour
// (R1) Channel power loss trips the channel
// (R2) Computing card removal trips the channel
// (R3) Input card removal faults inputs, alarms, no trip
// (R4) Output card removal alarms, forces both outputs tripped
// (R5) Untripped inputs keep relays energized, no trip
// (R6) Channel trip drives its relay in every cabinet
// (R7) Relay contacts form two-of-four coincidence
// (R8) Coincidence removes power from own breaker
// (R9) Breaker pairs AB, AD, BC, CD cut rods
// (R10) Lost link faults every signal it carries
// (R11) Faulted signals excluded; lone own signal passes
// (R12) Second-max/min for analog, two-of-four for contacts
// (R13) Selection holds while two signals stay valid
// (R14) Input fault reduces voting to two-of-three
// (R15) Channels A-C also compute safeguards logic
// (R16) Manual trip switch in series with coil
// (R17) Coil power loss energizes shunt trip relay
// (R18) Shunt trip power loss announced as inoperable
// (R19) Shunt and undervoltage devices tested independently
// (R20) Trip on flux, temperature, pressure, building, turbine, feedwater
// (R21) Building pressure from own independent sensor
// (R22) Second-highest flux above setpoint trips channel
// (R23) Single building contact only alarms; two trip
// (R24) Active-low trips, voting re-evaluated every cycle
module protective_channel_voter #(
	parameter logic [1:0] CH_ID = 2'h0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_ok,
	input wire logic cpu_ok,
	input wire logic in_card_ok,
	input wire logic out_card_ok,
	input wire logic shunt_pwr_ok,
	input wire logic [3:0] link_ok,
	input wire logic [3:0] trip_in_n,
	input wire logic [3:0] turb_open,
	input wire logic [3:0] bldg_open,
	input wire logic [3:0] fwa_open,
	input wire logic [3:0] fwb_open,
	input wire logic [2:0] pumps,
	input wire logic [3:0][15:0] flux_in,
	input wire logic [3:0][15:0] temp_in,
	input wire logic [3:0][15:0] press_in,
	input wire logic [3:0][15:0] flow_in,
	output logic chan_trip_n,
	output logic [1:0] brk_hold,
	output logic input_fault_alarm,
	output logic trouble_alarm,
	output logic shunt_inop_alarm,
	output logic safeguards_act
);
	localparam logic HAS_SG = (CH_ID != 2'h3);

	// Two-of-four over valid contacts; three valid makes it two-of-three
	function automatic logic vote2(input logic [3:0] open,
		input logic [3:0] ok);
		return $countones(open & ok) >= 2;
	endfunction : vote2

	// APB word index, or IDX_NONE for unmapped or misaligned addresses
	function automatic logic [3:0] reg_idx(input logic [7:0] a);
		if (a[1:0] != 2'h0 || a > `OFS_STATUS) begin
			return `IDX_NONE;
		end
		return a[5:2];
	endfunction : reg_idx

	voter_pkg::state_s q;
	voter_pkg::state_s d;
	voter_pkg::pins_s raw;
	logic [3:0] valid;
	logic [3:0] rel;
	logic [3:0][15:0] hi;
	logic [3:0][15:0] lo;
	logic [3:0] sok;
	logic coinc;
	logic ch_trip;
	logic bldg_one;
	logic [15:0] status;

	assign raw = {power_ok, cpu_ok, in_card_ok, out_card_ok, shunt_pwr_ok,
		link_ok, trip_in_n, turb_open, bldg_open, fwa_open, fwb_open,
		pumps, flow_in, press_in, temp_in, flux_in};

	// Own slot valid while the input card sits; peers while the link lives
	for (genvar j = 0; j < 4; j++) begin : g_chan
		assign valid[j] = (j == CH_ID) ? q.sync2.in_card_ok // R3
			: q.sync2.link_ok[j]; // R10
		// Own relay follows this channel's registered trip
		assign rel[j] = (j == CH_ID) ? q.chan_trip_n // R6
			: q.sync2.trip_in_n[j];
	end

	// One selector for each analog parameter
	for (genvar g = 0; g < 4; g++) begin : g_sel
		sel_if sif ();
		assign sif.vals = q.sync2.ana[g];
		assign sif.valid = valid;
		assign sif.own = CH_ID;
		analog_selector u_sel (
			.bus(sif.sel)
		);
		assign hi[g] = sif.hi2;
		assign lo[g] = sif.lo2;
		assign sok[g] = sif.ok;
	end

	// Channel trip decision, recomputed every cycle from current validity
	always_comb begin
		logic t_flux;
		logic t_flow;
		logic t_pump;
		logic t_temp;
		logic t_phi;
		logic t_plo;
		logic t_pt;
		logic armed;
		t_flux = !sok[`P_FLUX] ||
			hi[`P_FLUX] > q.sp[`SP_FLUX_HI]; // R22
		t_flow = !sok[`P_FLOW] || {1'b0, hi[`P_FLUX]} >
			{1'b0, lo[`P_FLOW]} + {1'b0, q.sp[`SP_FLOW_MGN]}; // R20
		t_pump = q.sync2.pumps < `PUMPS_FULL &&
			hi[`P_FLUX] > q.sp[`SP_PUMP_LIM]; // R20
		t_temp = !sok[`P_TEMP] ||
			hi[`P_TEMP] > q.sp[`SP_TEMP_HI]; // R20
		t_phi = !sok[`P_PRESS] ||
			hi[`P_PRESS] > q.sp[`SP_PRESS_HI]; // R20
		t_plo = !sok[`P_PRESS] ||
			lo[`P_PRESS] < q.sp[`SP_PRESS_LO]; // R20
		// Low pressure at high temperature crosses the P-T boundary
		t_pt = {1'b0, lo[`P_PRESS]} <
			{1'b0, hi[`P_TEMP]} + {1'b0, q.sp[`SP_PT_BIAS]}; // R20
		// Turbine and feedwater trips stay bypassed below startup flux
		armed = q.ctrl_en && hi[`P_FLUX] >= q.sp[`SP_BYP_FLUX];
		ch_trip = !q.sync2.power_ok || !q.sync2.cpu_ok; // R1 R2
		ch_trip = ch_trip || t_flux || t_flow || t_pump || t_temp; // R20
		ch_trip = ch_trip || t_phi || t_plo || t_pt; // R20
		ch_trip = ch_trip || vote2(q.sync2.bldg_open, valid); // R21 R23
		ch_trip = ch_trip || (armed &&
			vote2(q.sync2.turb_open, valid)); // R12 R14
		ch_trip = ch_trip || (armed && vote2(q.sync2.fwa_open, valid) &&
			vote2(q.sync2.fwb_open, valid)); // R20
	end

	// A tripped relay is a de-energized one, no validity masking here
	assign coinc = vote2(~rel, 4'hF); // R7
	assign bldg_one = $countones(q.sync2.bldg_open & valid) == 1; // R23

	// Readable view of the channel's own state
	always_comb begin
		status = 16'h0000;
		status[`ST_TRIP] = !q.chan_trip_n;
		status[`ST_COINC] = coinc;
		status[`ST_RELAY +: 4] = ~rel;
		status[`ST_LINKF +: 4] = ~q.sync2.link_ok;
		status[`ST_INF] = q.input_fault_alarm;
		status[`ST_OUTF] = !q.sync2.out_card_ok;
		status[`ST_BLDG1] = bldg_one;
		status[`ST_SHUNT] = q.shunt_inop_alarm;
		status[`ST_SG] = q.safeguards_act;
		status[`ST_SELF] = ch_trip;
	end

	// Next state: synchronisers, outputs and the APB slave
	always_comb begin
		logic [3:0] idx;
		idx = reg_idx(paddr);
		d = q;
		d.sync1 = raw;
		d.sync2 = q.sync1;
		d.chan_trip_n = !ch_trip; // R6 R24
		// Energized hold only while no coincidence and output card sits
		d.brk_hold = {2{!coinc && q.sync2.out_card_ok}}; // R4 R5 R8
		d.input_fault_alarm = !q.sync2.in_card_ok; // R3
		d.trouble_alarm = !q.sync2.out_card_ok || bldg_one; // R4 R23
		d.shunt_inop_alarm = !q.sync2.shunt_pwr_ok; // R18
		d.safeguards_act = HAS_SG && (vote2(q.sync2.bldg_open, valid) ||
			(!sok[`P_PRESS] ||
			lo[`P_PRESS] < q.sp[`SP_PRESS_LO])); // R15
		// Zero-wait slave: read data is prepared during the setup cycle
		d.pready = psel && !penable;
		d.pslverr = psel && !penable && idx == `IDX_NONE;
		d.prdata = 32'h0000_0000;
		if (psel && !penable) begin
			if (idx == `IDX_CTRL) begin
				d.prdata = {31'h0000_0000, q.ctrl_en};
			end else if (idx <= `IDX_SP_LAST) begin
				d.prdata = {16'h0000, q.sp[3'(idx - 4'h1)]};
			end else if (idx == `IDX_STATUS) begin
				d.prdata = {16'h0000, status};
			end
		end
		// Writes land on the edge that samples pready high
		if (psel && penable && pwrite && q.pready) begin
			if (idx == `IDX_CTRL) begin
				d.ctrl_en = pwdata[`CTRL_EN];
			end else if (idx <= `IDX_SP_LAST) begin
				d.sp[3'(idx - 4'h1)] = pwdata[15:0];
			end
		end
	end

	// Reset leaves the channel tripped and every breaker unpowered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ctrl_en <= `CTRL_RESET;
			q.sp <= `SP_RESET;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign chan_trip_n = q.chan_trip_n;
	assign brk_hold = q.brk_hold;
	assign input_fault_alarm = q.input_fault_alarm;
	assign trouble_alarm = q.trouble_alarm;
	assign shunt_inop_alarm = q.shunt_inop_alarm;
	assign safeguards_act = q.safeguards_act;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_pwr_lost;
		!q.sync2.power_ok;
	endsequence
	sequence s_cpu_out;
		q.sync2.power_ok && !q.sync2.cpu_ok;
	endsequence
	sequence s_coinc;
		$countones(~rel) >= 2;
	endsequence

	property p_r1;
		s_pwr_lost |=> !chan_trip_n;
	endproperty
	a_r1: assert property (p_r1) else $error("power loss no trip"); // R1
	property p_r2;
		s_cpu_out |=> !chan_trip_n && status[`ST_TRIP];
	endproperty
	a_r2: assert property (p_r2) else $error("card pull no trip"); // R2
	property p_r3;
		!q.sync2.in_card_ok |-> !valid[CH_ID] ##1 input_fault_alarm;
	endproperty
	a_r3: assert property (p_r3) else $error("input card fault"); // R3
	property p_r4;
		!q.sync2.out_card_ok |=> brk_hold == 2'b00 && trouble_alarm;
	endproperty
	a_r4: assert property (p_r4) else $error("output card fault"); // R4
	property p_r5;
		rel == 4'hF && q.sync2.out_card_ok |=> brk_hold == 2'b11;
	endproperty
	a_r5: assert property (p_r5) else $error("relay not held"); // R5
	property p_r7;
		s_coinc |=> brk_hold == 2'b00;
	endproperty
	a_r7: assert property (p_r7) else $error("no coincidence trip"); // R7
	property p_r10;
		(valid & ~q.sync2.link_ok & ~(4'h1 << CH_ID)) == 4'h0;
	endproperty
	a_r10: assert property (p_r10) else $error("lost link used"); // R10
	property p_r11;
		valid == (4'h1 << CH_ID) |-> sok[`P_FLUX] &&
			hi[`P_FLUX] == q.sync2.ana[`P_FLUX][CH_ID];
	endproperty
	a_r11: assert property (p_r11) else $error("own not passed"); // R11
	property p_r15;
		vote2(q.sync2.bldg_open, valid) |=> safeguards_act == HAS_SG;
	endproperty
	a_r15: assert property (p_r15) else $error("safeguards on D"); // R15
	property p_r18;
		!q.sync2.shunt_pwr_ok |=> shunt_inop_alarm;
	endproperty
	a_r18: assert property (p_r18) else $error("shunt inop silent"); // R18
	property p_r22;
		sok[`P_FLUX] && hi[`P_FLUX] > q.sp[`SP_FLUX_HI] |=> !chan_trip_n;
	endproperty
	a_r22: assert property (p_r22) else $error("flux no trip"); // R22
	property p_r23;
		bldg_one |=> trouble_alarm;
	endproperty
	a_r23: assert property (p_r23) else $error("single contact silent"); // R23
	property p_apb;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer timing");

	// Trip follows its cause one edge later and never latches
	sequence s_own_trip;
		ch_trip;
	endsequence
	sequence s_own_clear;
		!ch_trip;
	endsequence
	property p_r6;
		s_own_trip |=> !chan_trip_n && !rel[CH_ID];
	endproperty
	a_r6: assert property (p_r6) else $error("own relay not tripped"); // R6
	property p_r24;
		s_own_clear |=> chan_trip_n;
	endproperty
	a_r24: assert property (p_r24) else $error("trip held over"); // R24

	// Voting from the synced view; faulted inputs drop out of the count
	property p_r12;
		valid == 4'hF && $countones(q.sync2.bldg_open) >= 2 |=>
			!chan_trip_n;
	endproperty
	a_r12: assert property (p_r12) else $error("contact vote no trip"); // R12
	property p_r13;
		$countones(valid) >= 2 |-> sok[`P_FLUX] && sok[`P_PRESS];
	endproperty
	a_r13: assert property (p_r13) else $error("selection dropped"); // R13
	property p_r14;
		$countones(valid) == 3 &&
			$countones(q.sync2.bldg_open & valid) == 2 |=> !chan_trip_n;
	endproperty
	a_r14: assert property (p_r14) else $error("two of three no trip"); // R14
	property p_r20;
		sok[`P_PRESS] && lo[`P_PRESS] < q.sp[`SP_PRESS_LO] |=>
			!chan_trip_n;
	endproperty
	a_r20: assert property (p_r20) else $error("low pressure no trip"); // R20
endmodule : protective_channel_voter
`default_nettype wire

// ### far_side.sv
// Far-side model: peer relay drives, link status and rod breakers
`timescale 1ns/1ns
`default_nettype none
module far_side (
	input wire logic chan_trip_n,
	input wire logic [1:0] brk_hold,
	input wire logic [3:0] peer_trip,
	input wire logic [3:0] link_drop,
	input wire logic man_trip,
	output logic [3:0] trip_in_n,
	output logic [3:0] link_ok,
	output logic rods_powered,
	output logic shunt_fire
);
	logic [3:0] coil;
	logic coin;
	// Own relay follows this channel; hardwired, so links do not touch it
	assign trip_in_n = {~peer_trip[3:1], chan_trip_n};
	assign link_ok = ~link_drop;
	// Peer breakers open once any two channels trip
	assign coin = $countones({peer_trip[3:1], ~chan_trip_n}) >= 2;
	// Manual switch sits in series with every coil
	assign coil = {{3{~coin}}, &brk_hold} & {4{~man_trip}};
	// Shunt relay in parallel with the coil, tested on its own pin
	assign shunt_fire = ~coil[0];
	// A with C in one path, B with D in the other
	assign rods_powered = (coil[0] & coil[2]) | (coil[1] & coil[3]);
endmodule : far_side
`default_nettype wire

// ### tb_protective_channel_voter.sv
// Self-checking bench for the protective channel voter
`timescale 1ns/1ns
`default_nettype none
`include "voter_cfg.svh"
module tb_protective_channel_voter;
	localparam logic [7:0] SP_ONES = 8'h67; // Slots resetting to all ones
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic power_ok, cpu_ok, in_card_ok, out_card_ok, shunt_pwr_ok;
	logic [3:0] link_ok, trip_in_n, turb_open, bldg_open, fwa_open, fwb_open;
	logic [3:0] peer_trip, link_drop;
	logic [2:0] pumps;
	logic [3:0][15:0] flux_in, temp_in, press_in, flow_in;
	logic chan_trip_n, input_fault_alarm, trouble_alarm, shunt_inop_alarm;
	logic safeguards_act, rods_powered, man_trip, shunt_fire;
	logic [1:0] brk_hold;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;

	// 4 ns clock
	always #2 pclk = ~pclk;

	protective_channel_voter #(.CH_ID(2'h0)) i_protective_channel_voter (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_ok(power_ok), .cpu_ok(cpu_ok), .in_card_ok(in_card_ok),
		.out_card_ok(out_card_ok), .shunt_pwr_ok(shunt_pwr_ok),
		.link_ok(link_ok), .trip_in_n(trip_in_n), .turb_open(turb_open),
		.bldg_open(bldg_open), .fwa_open(fwa_open), .fwb_open(fwb_open),
		.pumps(pumps), .flux_in(flux_in), .temp_in(temp_in),
		.press_in(press_in), .flow_in(flow_in), .chan_trip_n(chan_trip_n),
		.brk_hold(brk_hold), .input_fault_alarm(input_fault_alarm),
		.trouble_alarm(trouble_alarm), .shunt_inop_alarm(shunt_inop_alarm),
		.safeguards_act(safeguards_act));

	far_side i_far_side (.chan_trip_n(chan_trip_n), .brk_hold(brk_hold),
		.peer_trip(peer_trip), .link_drop(link_drop), .man_trip(man_trip),
		.trip_in_n(trip_in_n), .link_ok(link_ok),
		.rods_powered(rods_powered), .shunt_fire(shunt_fire));

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		num_checks++;
		if (seen !== ex) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk

	task print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Ceiling well above the run length, so a stuck handshake ends it
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			print_verdict();
		end
	end

	// One APB transfer; request held until the edge that samples pready
	// high, data taken there; only the bench timeout ends a stuck wait
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Pins take three edges to reach the outputs; one edge spare
	task settle;
		repeat (4) @(posedge pclk);
	endtask : settle

	task st(input string nm, input logic ex);
		settle();
		chk(nm, chan_trip_n, {31'h0, ex});
	endtask : st

	task t_reset;
		chk("trip in reset", chan_trip_n, 32'h0);
		chk("hold in reset", brk_hold, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		st("trip idle", 1'h1);
		chk("hold idle", brk_hold, 32'h3);
		chk("rods idle", rods_powered, 32'h1);
		$display("test reset done");
	endtask : t_reset

	task t_regs;
		int i;
		apb(`OFS_CTRL, 1'b0, 32'h0);
		chk("ctrl reset", rd, 32'h1);
		for (i = 0; i < 8; i++) begin
			apb(`OFS_SP_BASE + 8'(4 * i), 1'b0, 32'h0);
			chk("setpoint reset", rd, SP_ONES[i] ? 32'hFFFF : 32'h0);
		end
		apb(8'h28, 1'b0, 32'h0);
		chk("unmapped err", err, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(`OFS_SP_BASE, 1'b1, 32'hABCD0800);
		apb(`OFS_SP_BASE, 1'b0, 32'h0);
		chk("flux limit", rd, 32'h0800);
		$display("test registers done");
	endtask : t_regs

	task t_cards;
		power_ok <= 1'b0;
		st("power loss", 1'h0);
		power_ok <= 1'b1;
		cpu_ok <= 1'b0;
		st("cpu out", 1'h0);
		cpu_ok <= 1'b1;
		in_card_ok <= 1'b0;
		st("input card out", 1'h1);
		chk("input alarm", input_fault_alarm, 32'h1);
		in_card_ok <= 1'b1;
		out_card_ok <= 1'b0;
		st("output card out", 1'h1);
		chk("half trip", brk_hold, 32'h0);
		chk("card trouble", trouble_alarm, 32'h1);
		chk("one breaker", rods_powered, 32'h1);
		out_card_ok <= 1'b1;
		shunt_pwr_ok <= 1'b0;
		settle();
		chk("shunt inop", shunt_inop_alarm, 32'h1);
		shunt_pwr_ok <= 1'b1;
		$display("test cards done");
	endtask : t_cards

	task t_coinc;
		man_trip <= 1'b1;
		settle();
		chk("manual trip", rods_powered, 32'h0);
		chk("shunt backup", shunt_fire, 32'h1);
		man_trip <= 1'b0;
		peer_trip <= 4'h2;
		settle();
		chk("one peer", brk_hold, 32'h3);
		peer_trip <= 4'h6;
		settle();
		chk("two peers", brk_hold, 32'h0);
		chk("rods cut", rods_powered, 32'h0);
		peer_trip <= 4'h8;
		power_ok <= 1'b0;
		settle();
		settle();
		chk("own and peer", brk_hold, 32'h0);
		power_ok <= 1'b1;
		peer_trip <= 4'h0;
		st("peers clear", 1'h1);
		$display("test coincidence done");
	endtask : t_coinc

	task t_flux;
		flux_in <= {16'h0100, 16'h0100, 16'h0900, 16'h0100};
		st("one high flux", 1'h1);
		flux_in[2] <= 16'h0900;
		st("two high flux", 1'h0);
		flux_in <= {16'h0100, 16'h0100, 16'h0100, 16'h0900};
		link_drop <= 4'hE;
		st("own flux only", 1'h0);
		link_drop <= 4'hC;
		st("two valid", 1'h1);
		link_drop <= 4'h0;
		flux_in <= {4{16'h0100}};
		$display("test flux done");
	endtask : t_flux

	task t_contacts;
		bldg_open <= 4'h4;
		st("one bldg contact", 1'h1);
		chk("bldg trouble", trouble_alarm, 32'h1);
		bldg_open <= 4'h5;
		st("two bldg contacts", 1'h0);
		chk("safeguards", safeguards_act, 32'h1);
		link_drop <= 4'h2;
		st("bldg two of three", 1'h0);
		bldg_open <= 4'h0;
		link_drop <= 4'h2;
		turb_open <= 4'h6;
		st("turbine two of three", 1'h1);
		turb_open <= 4'hC;
		st("turbine trip", 1'h0);
		apb(`OFS_CTRL, 1'b1, 32'h0);
		st("turbine disabled", 1'h1);
		apb(`OFS_CTRL, 1'b1, 32'h1);
		turb_open <= 4'h0;
		link_drop <= 4'h0;
		fwa_open <= 4'h3;
		fwb_open <= 4'h1;
		st("one pump lost", 1'h1);
		fwb_open <= 4'h3;
		st("both pumps lost", 1'h0);
		fwa_open <= 4'h0;
		fwb_open <= 4'h0;
		$display("test contacts done");
	endtask : t_contacts

	// Low pressure and pump limit need their setpoints moved off reset
	task t_press;
		apb(`OFS_SP_BASE + 8'h0C, 1'b1, 32'h0000_2000);
		st("low pressure", 1'h0);
		chk("low press safeguards", safeguards_act, 32'h1);
		apb(`OFS_SP_BASE + 8'h0C, 1'b1, 32'h0000_0000);
		st("pressure normal", 1'h1);
		pumps <= 3'h3;
		apb(`OFS_SP_BASE + 8'h18, 1'b1, 32'h0000_0080);
		st("pump limit", 1'h0);
		pumps <= 3'h4;
		st("all pumps", 1'h1);
		$display("test pressure done");
	endtask : t_press

	// Healthy plant at time zero, reset held three cycles
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{power_ok, cpu_ok, in_card_ok, out_card_ok, shunt_pwr_ok} = 5'h1F;
		{turb_open, bldg_open, fwa_open, fwb_open} = 16'h0000;
		peer_trip = 4'h0;
		link_drop = 4'h0;
		man_trip = 1'b0;
		pumps = 3'h4;
		flux_in = {4{16'h0100}};
		temp_in = {4{16'h0100}};
		press_in = {4{16'h1000}};
		flow_in = {4{16'h0000}};
		repeat (2) @(posedge pclk);
		t_reset();
		t_regs();
		t_cards();
		t_coinc();
		t_flux();
		t_contacts();
		t_press();
		print_verdict();
	end
endmodule : tb_protective_channel_voter
`default_nettype wire
